// >>> hw/itcl_pkg.sv
// Constants and types shared by the interval timer count latch block
package itcl_pkg;

    // Port addresses of the two timers
    localparam logic [7:0] ITCL_T1_DATA_BASE = 8'h40;  // Timer one, counter 0 data port
    localparam logic [7:0] ITCL_T1_CTRL      = 8'h43;  // Timer one control word
    localparam logic [7:0] ITCL_T2_DATA_BASE = 8'h48;  // Timer two, counter 0 data port
    localparam logic [7:0] ITCL_T2_CTRL      = 8'h4b;  // Timer two control word

    // Counter population
    localparam int         ITCL_NUM_CNT      = 6;      // Two timers of three counters
    localparam logic [2:0] ITCL_CNT_PER_TMR  = 3'h3;   // Counters in one timer
    localparam logic [1:0] ITCL_NO_COUNTER   = 2'h3;   // Data port slot with no counter

    // Control word field positions
    localparam int ITCL_SEL_HI = 7;                    // Counter select, high bit
    localparam int ITCL_SEL_LO = 6;                    // Counter select, low bit
    localparam int ITCL_ACC_HI = 5;                    // Access format, high bit
    localparam int ITCL_ACC_LO = 4;                    // Access format, low bit
    localparam int ITCL_CFG_HI = 5;                    // Top of the stored settings

    // Control word field values
    localparam logic [1:0] ITCL_SEL_READBACK = 2'h3;   // Read-back command select
    localparam logic [1:0] ITCL_ACC_LATCH    = 2'h0;   // Counter latch command
    localparam logic [1:0] ITCL_RW_LSB       = 2'h1;   // Low byte only
    localparam logic [1:0] ITCL_RW_MSB       = 2'h2;   // High byte only
    localparam logic [1:0] ITCL_RW_WORD      = 2'h3;   // Low byte then high byte

    // Values after reset
    localparam logic [5:0] ITCL_CFG_RST   = 6'h30;     // Two-byte format, mode 0, binary
    localparam logic [7:0] ITCL_RDATA_RST = 8'h00;     // Read data after reset and on unmapped reads

    // Types
    typedef logic [15:0] itcl_count_t;                 // One counter value
    typedef logic [7:0]  itcl_byte_t;                  // One bus byte
    typedef logic [5:0]  itcl_cfg_t;                   // Format, mode and countdown type

endpackage

// >>> hw/itcl_unit_if.sv
// Carrier between the port decoder and one counter latch unit
`timescale 1ns/1ns
interface itcl_unit_if;
    import itcl_pkg::*;

    logic        latch_cmd;    // Latch command for this counter, one cycle
    logic        cfg_wr;       // Normal control word for this counter, one cycle
    itcl_cfg_t   cfg_data;     // Settings carried by the control word
    logic        rd_strobe;    // Data port read, one cycle
    itcl_count_t live;         // Running count from the counting element
    itcl_byte_t  rdata;        // Byte that the current read returns
    logic        latched;      // A captured count is waiting to be read
    itcl_cfg_t   cfg;          // Stored settings

    // Decoder side
    modport ctl  (output latch_cmd, cfg_wr, cfg_data, rd_strobe, live,
                  input  rdata, latched, cfg);
    // Counter side
    modport unit (input  latch_cmd, cfg_wr, cfg_data, rd_strobe, live,
                  output rdata, latched, cfg);
endinterface

// >>> hw/itcl_latch_unit.sv
// Output latch and byte sequencing of one counter
`timescale 1ns/1ns
module itcl_latch_unit (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Decoder link
    itcl_unit_if.unit bus
);
    import itcl_pkg::*;

    itcl_cfg_t   cfg_r;        // Format, mode and countdown type
    itcl_count_t hold_r;       // Captured count
    logic        latched_r;    // Captured count not yet consumed
    logic        msb_next_r;   // Next two-byte read returns the high byte
    itcl_count_t src;          // Value that reads take bytes from
    logic [1:0]  rw_fmt;       // Programmed read format
    logic        take_msb;     // Current read returns the high byte
    logic        last_byte;    // Current read ends the value

    ////////////////////////////////////////////////////////////////////////
    // Read byte selection

    // Captured count has priority over the running count
    always_comb begin
        rw_fmt    = cfg_r[ITCL_CFG_HI -: 2];
        // (RULE8) latched value first
        src       = latched_r ? hold_r : bus.live;
        // (RULE3) byte by format
        take_msb  = (rw_fmt == ITCL_RW_MSB) || ((rw_fmt == ITCL_RW_WORD) && msb_next_r);
        last_byte = (rw_fmt != ITCL_RW_WORD) || msb_next_r;
        bus.rdata = take_msb ? src[15:8] : src[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings

    // A latch command never reaches this register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_r <= ITCL_CFG_RST;
        end else if (bus.cfg_wr) begin
            // (RULE7) only normal words
            cfg_r <= bus.cfg_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture and release

    // Capture on the first latch command, release after the last byte
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            latched_r <= 1'b0;
            hold_r    <= '0;
        end else if (bus.cfg_wr) begin
            // Reprogramming drops a pending capture
            latched_r <= 1'b0;
        end else if (bus.latch_cmd && !latched_r) begin
            // (RULE1) capture running count
            hold_r    <= bus.live;
            latched_r <= 1'b1;
        end else if (bus.rd_strobe && last_byte) begin
            // (RULE11) release after last byte
            latched_r <= 1'b0;
        end
        // (RULE2) later latch commands ignored while latched_r is set
    end

    // Byte pointer toggles only on reads of this counter's own port and clears on reprogramming
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            msb_next_r <= 1'b0;
        end else if (bus.cfg_wr) begin
            msb_next_r <= 1'b0;
        end else if (bus.rd_strobe && (rw_fmt == ITCL_RW_WORD)) begin
            // (RULE4) high byte kept pending
            msb_next_r <= !msb_next_r;
        end
    end

    // Status toward the decoder
    assign bus.latched = latched_r;
    assign bus.cfg     = cfg_r;

endmodule

// >>> hw/itcl_count_latch_top.sv
// Counter latch command handling for two three-counter interval timers
//
// Overview of operation
// (RULE1) Latch command captures running count, counting continues
// (RULE2) Further latch ignored until capture fully read
// (RULE3) Software reads capture in programmed byte format
// (RULE4) Pending high byte survives other counters' accesses
// (RULE5) Control bits 7:6 select counter or read-back
// (RULE6) Bits 5:4 zero means counter latch command
// (RULE7) Latch command leaves mode and format unchanged
// (RULE8) Reads return capture until its bytes consumed
// (RULE9) Capture read through each counter's own port
// (RULE10) Software finishes both bytes before switching routines
// (RULE11) After full read, running count returns again
// (RULE12) Timer one data ports at 040h upward
// (RULE13) Low four command bits written zero, ignored
`timescale 1ns/1ns
module itcl_count_latch_top (
    // Clock and reset
    input  wire logic                                           clock,
    input  wire logic                                           sys_rst,
    // I/O port access
    input  wire logic [7:0]                                     io_addr,
    input  wire logic [7:0]                                     io_wdata,
    input  wire logic                                           io_wr,
    input  wire logic                                           io_rd,
    output      logic [7:0]                                     io_rdata,
    output      logic                                           io_rdata_valid,
    // Running counts from the counting elements
    input  wire itcl_pkg::itcl_count_t [itcl_pkg::ITCL_NUM_CNT-1:0] live_count,
    // Counter state
    output      logic [itcl_pkg::ITCL_NUM_CNT-1:0]              latched,
    output      itcl_pkg::itcl_cfg_t [itcl_pkg::ITCL_NUM_CNT-1:0]   cnt_cfg
);
    import itcl_pkg::*;

    logic                          ctrl_hit;     // Access to a control word
    logic                          data_hit;     // Access to a counter data port
    logic                          tmr;          // Timer two addressed
    logic [1:0]                    cidx;         // Counter within the timer
    logic [2:0]                    uidx;         // Counter across both timers
    logic                          is_latch;     // Control word is a latch command
    logic                          is_normal;    // Control word programs a counter
    itcl_byte_t [ITCL_NUM_CNT-1:0] unit_byte;    // Read byte of each counter
    logic [ITCL_NUM_CNT-1:0]       unit_latched; // Capture pending per counter
    itcl_cfg_t [ITCL_NUM_CNT-1:0]  unit_cfg;     // Settings per counter

    ////////////////////////////////////////////////////////////////////////
    // Address and command decode

    // Find the addressed timer, counter and command kind
    always_comb begin
        ctrl_hit = 1'b0;
        data_hit = 1'b0;
        tmr      = 1'b0;
        cidx     = io_addr[1:0];
        if (io_addr == ITCL_T1_CTRL) begin
            ctrl_hit = 1'b1;
        end else if (io_addr == ITCL_T2_CTRL) begin
            ctrl_hit = 1'b1;
            tmr      = 1'b1;
        end else if ((io_addr[7:2] == ITCL_T1_DATA_BASE[7:2]) &&
                     (io_addr[1:0] != ITCL_NO_COUNTER)) begin
            // (RULE12) consecutive data ports
            data_hit = 1'b1;
        end else if ((io_addr[7:2] == ITCL_T2_DATA_BASE[7:2]) &&
                     (io_addr[1:0] != ITCL_NO_COUNTER)) begin
            data_hit = 1'b1;
            tmr      = 1'b1;
        end
        if (ctrl_hit) begin
            // (RULE5) counter select field
            cidx = io_wdata[ITCL_SEL_HI:ITCL_SEL_LO];
        end
        uidx = tmr ? (3'(cidx) + ITCL_CNT_PER_TMR) : 3'(cidx);
        // (RULE6) latch command decode
        is_latch  = (cidx != ITCL_SEL_READBACK) &&
                    (io_wdata[ITCL_ACC_HI:ITCL_ACC_LO] == ITCL_ACC_LATCH);
        // (RULE13) low bits not decoded
        is_normal = (cidx != ITCL_SEL_READBACK) &&
                    (io_wdata[ITCL_ACC_HI:ITCL_ACC_LO] != ITCL_ACC_LATCH);
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter latch units

    // One unit per counter, each with its own link
    itcl_unit_if u_if [ITCL_NUM_CNT] ();

    for (genvar g = 0; g < ITCL_NUM_CNT; g++) begin : g_cnt
        // Strobes reach only the addressed counter
        assign u_if[g].latch_cmd = io_wr && ctrl_hit && is_latch && (uidx == 3'(g));
        assign u_if[g].cfg_wr    = io_wr && ctrl_hit && is_normal && (uidx == 3'(g));
        assign u_if[g].cfg_data  = io_wdata[ITCL_CFG_HI:0];
        // (RULE9) read via own port
        assign u_if[g].rd_strobe = io_rd && data_hit && (uidx == 3'(g));
        assign u_if[g].live      = live_count[g];
        assign unit_byte[g]      = u_if[g].rdata;
        assign unit_latched[g]   = u_if[g].latched;
        assign unit_cfg[g]       = u_if[g].cfg;

        itcl_latch_unit u_unit (
            .clock   (clock),
            .sys_rst (sys_rst),
            .bus     (u_if[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and status outputs

    // Read answer one cycle after the strobe, zero for unmapped ports
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_rdata       <= ITCL_RDATA_RST;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= io_rd;
            if (io_rd && data_hit) begin
                io_rdata <= unit_byte[uidx];
            end else if (io_rd) begin
                io_rdata <= ITCL_RDATA_RST;
            end
        end
    end

    // Registered copies of each counter's state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            latched <= '0;
            cnt_cfg <= {ITCL_NUM_CNT{ITCL_CFG_RST}};
        end else begin
            latched <= unit_latched;
            cnt_cfg <= unit_cfg;
        end
    end

endmodule

// >>> tb/itcl_latch_monitor.sv
// Port-level checker of the count latch block
`timescale 1ns/1ns
module itcl_latch_monitor (
    // Clock and reset
    input wire logic                                            clock,
    input wire logic                                            sys_rst,
    // I/O port access
    input wire logic [7:0]                                      io_addr,
    input wire logic [7:0]                                      io_wdata,
    input wire logic                                            io_wr,
    input wire logic                                            io_rd,
    input wire logic [7:0]                                      io_rdata,
    input wire logic                                            io_rdata_valid,
    // Counter state
    input wire itcl_pkg::itcl_count_t [itcl_pkg::ITCL_NUM_CNT-1:0] live_count,
    input wire logic [itcl_pkg::ITCL_NUM_CNT-1:0]               latched,
    input wire itcl_pkg::itcl_cfg_t [itcl_pkg::ITCL_NUM_CNT-1:0]   cnt_cfg
);
    import itcl_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Latch command to timer one counter 0
    sequence latch_c0_s;
        io_wr && io_addr == ITCL_T1_CTRL && io_wdata[7:4] == 4'h0;
    endsequence
    // A cycle with no port read
    sequence quiet_s;
        !io_rd;
    endsequence
    rd_answer_a: assert property (io_rd |=> io_rdata_valid)
        else $error("read not answered");
    no_answer_a: assert property (!io_rd |=> !io_rdata_valid)
        else $error("answer without read");
    rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read byte changed without read");
    latch_set_a: assert property (latch_c0_s ##1 quiet_s |=> latched[0])
        else $error("latch command not taken");
    latch_cfg_a: assert property (latch_c0_s |-> ##2 cnt_cfg[0] == $past(cnt_cfg[0]))
        else $error("latch command changed settings");
    readback_a: assert property (io_wr && io_addr == ITCL_T1_CTRL &&
        io_wdata[7:6] == ITCL_SEL_READBACK |-> ##2 cnt_cfg == $past(cnt_cfg))
        else $error("read-back select changed settings");
    program_a: assert property (io_wr && io_addr == ITCL_T2_CTRL && io_wdata[7:6] == 2'h2 &&
        io_wdata[5:4] != ITCL_ACC_LATCH |-> ##2 cnt_cfg[5] == $past(io_wdata[5:0], 2))
        else $error("counter select decoded wrongly");
    latch_keep_a: assert property (!io_rd && !io_wr |-> ##2 $stable(latched))
        else $error("capture state changed without access");
    unmapped_a: assert property (io_rd && io_addr == 8'h47 |=> io_rdata == ITCL_RDATA_RST)
        else $error("unmapped read not zero");
endmodule
bind itcl_count_latch_top itcl_latch_monitor u_itcl_latch_monitor (.clock, .sys_rst, .io_addr,
    .io_wdata, .io_wr, .io_rd, .io_rdata, .io_rdata_valid, .live_count, .latched, .cnt_cfg);

// >>> tb/test_interval_timer_count_latch.sv
// Self-checking bench of the count latch block
`timescale 1ns/1ns
module test_interval_timer_count_latch;
    import itcl_pkg::*;
    // Stimulus, observed outputs and counters
    logic                           clock = 1'b0;
    logic                           sys_rst = 1'b1;
    logic [7:0]                     io_addr = 8'h00;
    logic [7:0]                     io_wdata = 8'h00;
    logic                           io_wr = 1'b0;
    logic                           io_rd = 1'b0;
    logic [7:0]                     io_rdata;
    logic                           io_rdata_valid;
    itcl_count_t [ITCL_NUM_CNT-1:0] live_count = '0;
    logic [ITCL_NUM_CNT-1:0]        latched;
    itcl_cfg_t [ITCL_NUM_CNT-1:0]   cnt_cfg;
    int                             fail_count = 0;
    int                             n_tests = 0;
    // Block under test
    itcl_count_latch_top u_itcl_count_latch_top (.clock, .sys_rst, .io_addr, .io_wdata, .io_wr,
        .io_rd, .io_rdata, .io_rdata_valid, .live_count, .latched, .cnt_cfg);
    // Clock, 10 ns period
    initial begin
        forever #5 clock = ~clock;
    end
    // Counts and verdict, then end of run
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One comparison
    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        n_tests++;
        if (act !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, act, exp);
        end
    endtask
    // One port write, one-cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
    endtask
    // One port read, answer looked at just after the take edge, while valid stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        #1;
        chk(16'(io_rdata_valid), 16'h0001);
        chk(16'(io_rdata), 16'(exp));
    endtask
    // Let the lagging state outputs settle
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    // Two-byte capture, second latch ignored, other counter in between
    task automatic s_two_byte();
        live_count[0] <= 16'h1234;
        wr(ITCL_T1_CTRL, 8'h00);
        live_count[0] <= 16'h5678;
        wr(ITCL_T1_CTRL, 8'h00);
        wr(ITCL_T1_CTRL, 8'h40);
        settle();
        chk(16'(latched), 16'h0003);
        rd(ITCL_T1_DATA_BASE, 8'h34);
        rd(ITCL_T1_DATA_BASE + 8'h1, 8'hbc);
        // counter 0 high byte read after the counter 1 read
        rd(ITCL_T1_DATA_BASE, 8'h12);
        rd(ITCL_T1_DATA_BASE, 8'h78);
    endtask
    // Low-byte format on timer two counter 2, low command bits written zero
    task automatic s_one_byte();
        wr(ITCL_T2_CTRL, 8'h90);
        live_count[5] <= 16'habcd;
        wr(ITCL_T2_CTRL, 8'h80);
        live_count[5] <= 16'h0011;
        settle();
        chk(16'(cnt_cfg[5]), 16'h0010);
        chk(16'(latched[5]), 16'h0001);
        rd(ITCL_T2_DATA_BASE + 8'h2, 8'hcd);
        rd(ITCL_T2_DATA_BASE + 8'h2, 8'h11);
    endtask
    // Read-back select ignored, unmapped and live reads
    task automatic s_refused();
        wr(ITCL_T1_CTRL, 8'hc2);
        settle();
        chk(16'(cnt_cfg[0]), 16'(ITCL_CFG_RST));
        chk(16'(latched), 16'h0002);
        rd(8'h47, ITCL_RDATA_RST);
        rd(ITCL_T1_DATA_BASE + 8'h2, 8'h0d);
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        live_count[1] <= 16'h9abc;
        live_count[2] <= 16'h0c0d;
        #1;
        chk(16'(cnt_cfg[0]), 16'(ITCL_CFG_RST));
        s_two_byte();
        s_one_byte();
        s_refused();
        print_verdict();
    end
endmodule
